// >>> dpsg_pkg.sv
// Shared constants and types for the DRAM pin signalling block
package dpsg_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 29;
  localparam int LANES = 4;
  localparam int BLOCKS = 2;

  // ----------------------------------------------------------------
  // Port size codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PS_32 = 2'h0;
  localparam logic [1:0] PS_8 = 2'h1;
  localparam logic [1:0] PS_16 = 2'h2;
  localparam logic [3:0] LANE_MASK_32 = 4'hf;
  localparam logic [3:0] LANE_MASK_16 = 4'hc;
  localparam logic [3:0] LANE_MASK_8 = 4'h8;

  // ----------------------------------------------------------------
  // Reset and idle pin levels
  // ----------------------------------------------------------------
  localparam logic [1:0] ROW_IDLE = 2'h3;
  localparam logic [3:0] COL_IDLE = 4'hf;
  localparam logic STROBE_IDLE = 1'h1;
  localparam logic CKE_RESET = 1'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int T_ROW_TO_COL_NS = 20;
  localparam int T_COL_PULSE_NS = 25;
  localparam int T_PRECHARGE_NS = 40;
  localparam int ROW_CYC = (T_ROW_TO_COL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int COL_CYC = (T_COL_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PRE_CYC = (T_PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STABLE_CYC = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ROW = 4'b0010,
    ST_COL = 4'b0100,
    ST_PRE = 4'b1000
  } dpsg_state_t;

  typedef enum logic [2:0] {
    MODE_RISE = 3'b001,
    MODE_FALL = 3'b010,
    MODE_LOOP = 3'b100
  } dpsg_mode_t;

endpackage

// >>> dpsg_sync2.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module dpsg_sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Level in and out
  input wire logic din,
  output logic dout
);
  logic meta;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// >>> dpsg_edge_mode.sv
// Classifies the edge-choice strap: tied high, tied low or looped clock
`timescale 1ns/1ps
module dpsg_edge_mode
  import dpsg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Synchronised strap level
  input wire logic lvl,
  // Classification
  output dpsg_mode_t mode,
  output logic rise
);
  logic prev;
  logic [3:0] stable_cnt;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev <= 1'b0;
      rise <= 1'b0;
    end else begin
      prev <= lvl;
      rise <= lvl & ~prev;
    end
  end

  // A toggling strap means loop-back; a steady one for a while means tied
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stable_cnt <= 4'h0;
      mode <= MODE_RISE;
    end else if (lvl != prev) begin
      stable_cnt <= 4'h0;
      mode <= MODE_LOOP;
    end else if (stable_cnt != 4'(STABLE_CYC)) begin
      stable_cnt <= stable_cnt + 4'h1;
    end else begin
      mode <= lvl ? MODE_RISE : MODE_FALL;
    end
  end
endmodule

// >>> dpsg_top.sv
// DRAM and SDRAM pin signalling for two memory blocks
// Functional notes
// - Ports of 8, 16 or 32 bits; up to 512 Mbytes addressed.
// - Two row strobes, one for each memory block.
// - SDRAM block uses its row strobe as chip select.
// - Four column strobes; byte masks when the block holds SDRAM.
// - Column strobe 3 is the least significant byte, 0 the most.
// - Write indicator asserted through a write cycle, negated for reads.
// - SDRAM row, column and clock enable outputs come straight from flops.
// - Registered clock enable feeds the SDRAM clock enable input.
// - Strap high: SDRAM controls change on the rising bus clock edge.
// - Strap low: SDRAM controls launch one bus cycle later, still on the rising bus clock edge.
// - Strap looped to SDRAM clock: launch on a rising bus clock edge once the synchronised strap is seen to rise.
// - All pin timing is referenced to the bus input clock.
`timescale 1ns/1ps
module dpsg_top
  import dpsg_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // Static configuration
  input wire logic [1:0] PORT_SIZE,
  input wire logic [BLOCKS-1:0] BLOCK_IS_SDRAM,
  input wire logic OUTPUT_EDGE_CHOICE,
  // Access request from the controller core
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic REQ_BLOCK,
  input wire logic REQ_WRITE,
  input wire logic [LANES-1:0] REQ_BYTE_EN,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic REQ_SD_ROW,
  input wire logic REQ_SD_COL,
  input wire logic REQ_SD_CKE,
  // Memory pins
  output logic [BLOCKS-1:0] ROW_STROBE_N,
  output logic [LANES-1:0] COL_STROBE_N,
  output logic MEM_WRITE_INDICATOR_N,
  output logic SYNC_ROW_CMD_STROBE_N,
  output logic SYNC_COL_CMD_STROBE_N,
  output logic SYNC_MEM_CLOCK_ENABLE,
  output logic [ADDR_W-1:0] MEM_ADDR
);

  // ----------------------------------------------------------------
  // Edge strap handling
  // ----------------------------------------------------------------
  logic edge_lvl;
  logic edge_rise;
  dpsg_mode_t mode;

  dpsg_sync2 u_sync (
    .clk(CLOCK),
    .nrst(NRST),
    .din(OUTPUT_EDGE_CHOICE),
    .dout(edge_lvl)
  );

  dpsg_edge_mode u_mode (
    .clk(CLOCK),
    .nrst(NRST),
    .lvl(edge_lvl),
    .mode(mode),
    .rise(edge_rise)
  );

  // ----------------------------------------------------------------
  // Byte lane mapping
  // ----------------------------------------------------------------
  function automatic logic [3:0] lane_mask(input logic [1:0] ps);
    case (ps)
      PS_8: lane_mask = LANE_MASK_8;
      PS_16: lane_mask = LANE_MASK_16;
      default: lane_mask = LANE_MASK_32;
    endcase
  endfunction

  logic [LANES-1:0] req_lanes;
  logic [LANES-1:0] req_col_n;
  assign req_lanes = REQ_BYTE_EN & lane_mask(PORT_SIZE);

  // Byte i of the data bus is governed by strobe 3-i
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++) begin : g_lane
      assign req_col_n[LANES-1-gi] = ~req_lanes[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Request acceptance
  // ----------------------------------------------------------------
  dpsg_state_t state;
  dpsg_state_t next_state;
  logic [3:0] cnt;
  logic stage_pend;
  logic stage_aged;
  logic launch_en;
  logic take;
  logic take_async;
  logic take_sd;
  logic held_block;
  logic held_write;
  logic [LANES-1:0] held_col_n;

  assign take = REQ_VALID & REQ_READY;
  assign take_sd = take & BLOCK_IS_SDRAM[REQ_BLOCK];
  assign take_async = take & ~BLOCK_IS_SDRAM[REQ_BLOCK];

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      held_block <= 1'b0;
      held_write <= 1'b0;
      held_col_n <= COL_IDLE;
    end else if (take_async) begin
      held_block <= REQ_BLOCK;
      held_write <= REQ_WRITE;
      held_col_n <= req_col_n;
    end
  end

  // ----------------------------------------------------------------
  // Asynchronous DRAM cycle sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take_async) begin
          next_state = ST_ROW;
        end
      end
      ST_ROW: begin
        if (cnt == 4'(ROW_CYC - 1)) begin
          next_state = ST_COL;
        end
      end
      ST_COL: begin
        if (cnt == 4'(COL_CYC - 1)) begin
          next_state = ST_PRE;
        end
      end
      ST_PRE: begin
        if (cnt == 4'(PRE_CYC - 1)) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      cnt <= 4'h0;
    end else if (next_state != state) begin
      cnt <= 4'h0;
    end else if (state != ST_IDLE) begin
      cnt <= cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // SDRAM command stage
  // ----------------------------------------------------------------
  logic [BLOCKS-1:0] stage_cs_n;
  logic [LANES-1:0] stage_dqm;
  logic stage_ras_n;
  logic stage_cas_n;
  logic stage_we_n;
  logic stage_cke;

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      stage_cs_n <= ROW_IDLE;
      stage_dqm <= COL_IDLE;
      stage_ras_n <= STROBE_IDLE;
      stage_cas_n <= STROBE_IDLE;
      stage_we_n <= STROBE_IDLE;
    end else if (take_sd) begin
      stage_cs_n <= ~(BLOCKS'(1) << REQ_BLOCK);
      stage_dqm <= req_col_n;
      stage_ras_n <= ~REQ_SD_ROW;
      stage_cas_n <= ~REQ_SD_COL;
      stage_we_n <= ~REQ_WRITE;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      stage_cke <= CKE_RESET;
    end else begin
      stage_cke <= REQ_SD_CKE;
    end
  end

  // Falling-edge mode holds the command one extra bus cycle before launch
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      stage_pend <= 1'b0;
      stage_aged <= 1'b0;
    end else if (take_sd) begin
      stage_pend <= 1'b1;
      stage_aged <= 1'b0;
    end else if (launch_en) begin
      stage_pend <= 1'b0;
      stage_aged <= 1'b0;
    end else begin
      stage_aged <= stage_pend;
    end
  end

  always_comb begin
    case (mode)
      MODE_RISE: launch_en = 1'b1;
      MODE_FALL: launch_en = ~stage_pend | stage_aged;
      MODE_LOOP: launch_en = edge_rise;
      default: launch_en = 1'b1;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      REQ_READY <= 1'b0;
    end else begin
      REQ_READY <= (next_state == ST_IDLE) & ~take_sd & ~(stage_pend & ~launch_en);
    end
  end

  // ----------------------------------------------------------------
  // Pin registers, all timed from the bus clock
  // ----------------------------------------------------------------
  logic async_on;
  assign async_on = (next_state != ST_IDLE);

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      ROW_STROBE_N <= ROW_IDLE;
      COL_STROBE_N <= COL_IDLE;
      MEM_WRITE_INDICATOR_N <= STROBE_IDLE;
    end else if (async_on) begin
      ROW_STROBE_N <= (next_state == ST_PRE) ? ROW_IDLE
                    : ~(BLOCKS'(1) << (take_async ? REQ_BLOCK : held_block));
      COL_STROBE_N <= (next_state == ST_COL) ? held_col_n : COL_IDLE;
      MEM_WRITE_INDICATOR_N <= ~(take_async ? REQ_WRITE : held_write);
    end else if (launch_en) begin
      ROW_STROBE_N <= stage_pend ? stage_cs_n : ROW_IDLE;
      COL_STROBE_N <= stage_pend ? stage_dqm : COL_IDLE;
      MEM_WRITE_INDICATOR_N <= stage_pend ? stage_we_n : STROBE_IDLE;
    end else if (state != ST_IDLE) begin
      ROW_STROBE_N <= ROW_IDLE;
      COL_STROBE_N <= COL_IDLE;
      MEM_WRITE_INDICATOR_N <= STROBE_IDLE;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      SYNC_ROW_CMD_STROBE_N <= STROBE_IDLE;
      SYNC_COL_CMD_STROBE_N <= STROBE_IDLE;
      SYNC_MEM_CLOCK_ENABLE <= CKE_RESET;
    end else if (launch_en) begin
      SYNC_ROW_CMD_STROBE_N <= stage_pend ? stage_ras_n : STROBE_IDLE;
      SYNC_COL_CMD_STROBE_N <= stage_pend ? stage_cas_n : STROBE_IDLE;
      SYNC_MEM_CLOCK_ENABLE <= stage_cke;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      MEM_ADDR <= '0;
    end else if (take) begin
      MEM_ADDR <= REQ_ADDR;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  a_row_one_block: assert property ($countones(~ROW_STROBE_N) <= 1)
    else $error("both row strobes asserted");

  a_sd_chip_sel: assert property (
    (launch_en && stage_pend && !async_on) |=> ROW_STROBE_N == $past(stage_cs_n))
    else $error("SDRAM chip select not launched");

  a_col_in_row: assert property (
    (state == ST_COL) |-> (ROW_STROBE_N != ROW_IDLE && COL_STROBE_N == held_col_n))
    else $error("column strobe outside row cycle");

  a_lane_order: assert property (
    (take && PORT_SIZE == PS_32 && !BLOCK_IS_SDRAM[REQ_BLOCK])
    |-> ##(ROW_CYC + 1) COL_STROBE_N[3] == !$past(REQ_BYTE_EN[0], ROW_CYC + 1))
    else $error("low data byte not on strobe 3");

  a_write_held: assert property (
    (state != ST_IDLE) |-> MEM_WRITE_INDICATOR_N == !held_write)
    else $error("write indicator dropped during cycle");

  a_cke_launch: assert property (
    launch_en |=> SYNC_MEM_CLOCK_ENABLE == $past(stage_cke))
    else $error("clock enable not registered at launch");

  a_rise_launch: assert property (
    (mode == MODE_RISE && take_sd) |=> ##1 !SYNC_ROW_CMD_STROBE_N == $past(REQ_SD_ROW, 2))
    else $error("rising mode launch late");

  a_fall_hold: assert property (
    (mode == MODE_FALL && take_sd) |=> !launch_en ##1 launch_en)
    else $error("falling mode launch not delayed one cycle");

  a_loop_edge: assert property (
    (mode == MODE_LOOP && launch_en) |-> edge_rise)
    else $error("loop mode launch off clock edge");

  a_busy_ready: assert property ((state != ST_IDLE) |-> !REQ_READY)
    else $error("ready during asynchronous cycle");

  c_async_write: cover property (take_async && REQ_WRITE ##[1:8] state == ST_PRE);
  c_sd_rise: cover property (mode == MODE_RISE && take_sd);
  c_sd_fall: cover property (mode == MODE_FALL && take_sd ##2 launch_en);
  c_sd_loop: cover property (mode == MODE_LOOP && stage_pend && launch_en);
  c_narrow: cover property (take && PORT_SIZE == PS_8);

endmodule

// >>> dpsg_mem_model.sv
// Passive model of the DRAM and SDRAM devices on both memory blocks
`timescale 1ns/1ps
module dpsg_mem_model
  import dpsg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Board build, high where the block holds SDRAM
  input wire logic [BLOCKS-1:0] sd_fitted,
  // Memory pins
  input wire logic [BLOCKS-1:0] row_n,
  input wire logic [LANES-1:0] col_n,
  input wire logic wr_n,
  input wire logic srow_n,
  input wire logic scol_n,
  input wire logic cke,
  input wire logic [ADDR_W-1:0] addr,
  // Buffered SDRAM clock, looped back to the edge strap
  output logic sd_clk,
  // Access as the devices latched it
  output logic seen,
  output logic [BLOCKS-1:0] seen_row_n,
  output logic [LANES-1:0] seen_col_n,
  output logic seen_wr_n,
  output logic seen_srow_n,
  output logic seen_scol_n,
  output logic seen_cke,
  output logic [ADDR_W-1:0] seen_addr
);
  logic blk;
  logic hit;
  logic prev_hit;

  // Same rate as the bus clock, small buffer lag only
  assign #2 sd_clk = clk;

  // SDRAM latches on chip select, async DRAM on its first column strobe
  assign blk = row_n[0];
  assign hit = (row_n != ROW_IDLE) && (sd_fitted[blk] || col_n != COL_IDLE);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_hit <= 1'b0;
      seen <= 1'b0;
    end else begin
      prev_hit <= hit;
      seen <= hit && !prev_hit;
      if (hit && !prev_hit) begin
        seen_row_n <= row_n;
        seen_col_n <= col_n;
        seen_wr_n <= wr_n;
        seen_srow_n <= srow_n;
        seen_scol_n <= scol_n;
        seen_cke <= cke;
        seen_addr <= addr;
      end
    end
  end
endmodule

// >>> testbench.sv
// Self-checking bench for the DRAM pin signalling block
`timescale 1ns/1ps
module testbench;
  import dpsg_pkg::*;

  typedef struct packed {
    logic [1:0] row;
    logic [3:0] col;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic sd;
    logic srow;
    logic scol;
  } dpsg_exp_t;

  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] port_size = PS_32;
  logic [1:0] sd_fit = 2'h0;
  logic [1:0] edge_mode = 2'h1;
  logic valid = 1'b0;
  logic ready;
  logic blk = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'h0;
  logic [ADDR_W-1:0] addr = '0;
  logic sdr = 1'b0;
  logic sdc = 1'b0;
  logic cke_req = 1'b0;
  logic edge_pin;
  logic sd_clk;
  logic [1:0] row_n;
  logic [3:0] col_n;
  logic wr_n, srow_n, scol_n, cke;
  logic [ADDR_W-1:0] mem_addr;
  logic seen, s_wr, s_srow, s_scol, s_cke;
  logic [1:0] s_row;
  logic [3:0] s_col;
  logic [ADDR_W-1:0] s_addr;
  dpsg_exp_t exp_q[$];
  integer seed = 46;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  // ----------------------------------------------------------------
  // Clock, strap and instances
  // ----------------------------------------------------------------
  initial forever #12.5 clock = ~clock;

  assign edge_pin = (edge_mode == 2'h2) ? sd_clk : edge_mode[0];

  dpsg_top i_dpsg_top (.CLOCK(clock), .NRST(nrst), .PORT_SIZE(port_size),
    .BLOCK_IS_SDRAM(sd_fit), .OUTPUT_EDGE_CHOICE(edge_pin), .REQ_VALID(valid),
    .REQ_READY(ready), .REQ_BLOCK(blk), .REQ_WRITE(wr), .REQ_BYTE_EN(be),
    .REQ_ADDR(addr), .REQ_SD_ROW(sdr), .REQ_SD_COL(sdc), .REQ_SD_CKE(cke_req),
    .ROW_STROBE_N(row_n), .COL_STROBE_N(col_n), .MEM_WRITE_INDICATOR_N(wr_n),
    .SYNC_ROW_CMD_STROBE_N(srow_n), .SYNC_COL_CMD_STROBE_N(scol_n),
    .SYNC_MEM_CLOCK_ENABLE(cke), .MEM_ADDR(mem_addr));

  dpsg_mem_model i_dpsg_mem_model (.clk(clock), .nrst(nrst), .sd_fitted(sd_fit),
    .row_n(row_n), .col_n(col_n), .wr_n(wr_n), .srow_n(srow_n), .scol_n(scol_n),
    .cke(cke), .addr(mem_addr), .sd_clk(sd_clk), .seen(seen), .seen_row_n(s_row),
    .seen_col_n(s_col), .seen_wr_n(s_wr), .seen_srow_n(s_srow),
    .seen_scol_n(s_scol), .seen_cke(s_cke), .seen_addr(s_addr));

  // ----------------------------------------------------------------
  // Checking and verdict
  // ----------------------------------------------------------------
  task check(input logic [63:0] got, input logic [63:0] want);
    checked++;
    if (got !== want) begin
      num_errors++;
      $display("ERROR at %0t: pin value %h expected %h", $time, got, want);
    end
  endtask

  task give_verdict;
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(negedge clock) begin : watch
    dpsg_exp_t e;
    if (seen === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("ERROR at %0t: access seen with none pending", $time);
      end else begin
        e = exp_q.pop_front();
        check(64'(s_row), 64'(e.row));
        check(64'(s_col), 64'(e.col));
        check(64'(s_wr), 64'(e.wr));
        if (e.sd) begin
          check(64'({s_srow, s_scol}), 64'({e.srow, e.scol}));
          check(64'(s_cke), 64'h1);
        end
        check(64'(s_addr), 64'(e.addr));
      end
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      $display("ERROR at %0t: run did not finish", $time);
      give_verdict;
    end
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  task do_req;
    dpsg_exp_t e;
    logic [3:0] eff;
    logic [1:0] gap;
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 60) begin
      @(posedge clock);
      #1;
      k++;
    end
    blk = 1'($random(seed));
    wr = 1'($random(seed));
    be = 4'($random(seed));
    addr = ADDR_W'($random(seed));
    {sdr, sdc} = 2'h1 + 2'(($random(seed) & 32'h7fff) % 3);
    // An async cycle needs at least one lane that the port carries
    if (!sd_fit[blk])
      be[3] = 1'b1;
    eff = be & ((port_size == PS_8) ? LANE_MASK_8 :
                (port_size == PS_16) ? LANE_MASK_16 : LANE_MASK_32);
    for (k = 0; k < 4; k++)
      e.col[3-k] = ~eff[k];
    e.row = blk ? 2'h1 : 2'h2;
    e.wr = ~wr;
    e.addr = addr;
    e.sd = sd_fit[blk];
    e.srow = ~sdr;
    e.scol = ~sdc;
    exp_q.push_back(e);
    valid = 1'b1;
    @(posedge clock);
    #1;
    valid = 1'b0;
    gap = 2'($random(seed));
    repeat (gap) begin
      @(posedge clock);
      #1;
    end
  endtask

  task run_phase(input logic [1:0] ps, input logic [1:0] sd, input logic [1:0] em);
    port_size = ps;
    sd_fit = sd;
    edge_mode = em;
    cke_req = (sd != 2'h0);
    nrst = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    nrst = 1'b1;
    repeat (20) @(posedge clock);
    #1;
    repeat (8) do_req;
    repeat (12) @(posedge clock);
    #1;
  endtask

  initial begin
    run_phase(PS_32, 2'h0, 2'h1);
    run_phase(PS_16, 2'h0, 2'h0);
    run_phase(PS_8, 2'h0, 2'h1);
    run_phase(2'h3, 2'h2, 2'h1);
    run_phase(PS_32, 2'h3, 2'h0);
    run_phase(PS_16, 2'h3, 2'h2);
    check(64'(exp_q.size()), 64'h0);
    give_verdict;
  end
endmodule
